/* verilog/eeprom_loader.sv */
// Serial EEPROM autoloader and software byte master on a two-wire bus
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
// What this block does
// RULE1: SCL near, never above, 100 kHz
// RULE2: EEPROM addressed at 1010000b
// RULE3: Lines only pulled low or released
// RULE4: Start: SDA falls while SCL high
// RULE5: Stop: SDA rises while SCL high
// RULE6: SDA changes only while SCL low
// RULE7: Eight-bit bytes, each with ack slot
// RULE8: Ack is SDA low during SCL high
// RULE9: This block is sole bus master
// RULE10: SCL released and quiet when idle
// RULE11: Software single bytes; four-byte reads autoload-only
// RULE12: Write: address, offset, data, stop
// RULE13: Missing ack sets no-ack status flag
// RULE14: Read uses direction 1; master acks bytes
// RULE15: Autoload after PCI reset when present
// RULE16: Byte 00h splits MaxLat and MinGnt
// RULE17: Bytes 01h-04h load subsystem IDs
// RULE18: Byte 05h loads PHY bit, link bits
// RULE19: Byte 06h bits 6:5 give ROM offset
// RULE20: Presence from pulled-up SCL, else skip
// RULE21: Load after card functions' busy clears
// RULE22: Autoload no-ack aborts, keeps defaults; bytes loaded by earlier four-byte reads stay loaded
// RULE23: Reserved bytes read but never loaded
module eeprom_loader (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Host reset and load sequencing
  input wire logic pci_rst_n,
  input wire logic cb_load_busy,
  output logic load_busy,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Two-wire bus, open drain
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Loaded defaults
  output logic [3:0] max_lat,
  output logic [3:0] min_gnt,
  output logic [31:0] subsys_ids,
  output logic phy_prog_en,
  output logic [7:0] link_enh0,
  output logic [7:0] minirom_base,
  output logic [31:0] guid_hi,
  output logic [31:0] guid_lo
);
  typedef enum logic [3:0] {
    S_RESET = 4'b0000,
    S_WAIT_CB = 4'b0001,
    S_IDLE = 4'b0010,
    S_START = 4'b0011,
    S_DEVW = 4'b0100,
    S_OFFS = 4'b0101,
    S_WDATA = 4'b0110,
    S_RSTART = 4'b0111,
    S_DEVR = 4'b1000,
    S_RDATA = 4'b1001,
    S_STOP = 4'b1010
  } ld_state_t;

  ld_state_t state_reg, state_next;
  logic pci_s1_reg, pci_s2_reg, cb_s1_reg, cb_s2_reg;
  logic issued_reg, auto_reg, abort_reg, dir_reg;
  logic nack_reg, ldone_reg, pres_reg;
  logic [6:0] slave_reg;
  logic [7:0] offs_reg, data_reg;
  logic [4:0] rom_reg;
  logic [1:0] mini_reg;
  logic [8:0] eng_rx;
  logic eng_done, scl_level;
  logic [8*eeprom_loader_pkg::LD_BYTES-1:0] ld_flat;

  ////////////////////////////////////////////////////////////////////////
  // Decode

  wire pci_ok = pci_s2_reg;
  wire xfer = !(state_reg inside {S_RESET, S_WAIT_CB, S_IDLE});
  wire sw_busy = xfer && !auto_reg;
  wire eng_nack = eng_rx[0];
  wire [7:0] rx_byte = eng_rx[8:1];
  wire is_rd = auto_reg || (dir_reg == eeprom_loader_pkg::DIR_RD);
  wire ctrl_wr = reg_wr && reg_addr == eeprom_loader_pkg::REG_CTRL;
  wire cfg_wr = reg_wr && !xfer;
  // RULE11: software starts single-byte transfers only
  wire sw_go = ctrl_wr && reg_wdata[eeprom_loader_pkg::CTRL_GO] &&
               state_reg == S_IDLE && pci_ok;
  wire last_rd = !auto_reg || rom_reg[1:0] == eeprom_loader_pkg::DW_LAST;
  wire ack_state = state_reg inside {S_DEVW, S_OFFS, S_WDATA, S_DEVR};
  // RULE13: expected acknowledge missing
  wire ack_fail = eng_done && eng_nack && ack_state;
  wire ld_we = eng_done && state_reg == S_RDATA && auto_reg;
  wire [3:0] ld_off = rom_reg[3:0];
  wire clr_ld = state_reg == S_RESET;
  wire auto_end = state_reg == S_STOP && eng_done && auto_reg;
  wire [6:0] dev_addr = auto_reg ? eeprom_loader_pkg::EEPROM_ADDR
                                 : slave_reg;
  wire [7:0] word_off = auto_reg ? {3'h0, rom_reg} : offs_reg;
  wire eng_go = xfer && !issued_reg;

  // RULE9: only this block issues starts and clocks
  wire eeprom_loader_pkg::bus_op_t eng_op =
    (state_reg inside {S_START, S_RSTART}) ? eeprom_loader_pkg::OP_START :
    (state_reg == S_STOP) ? eeprom_loader_pkg::OP_STOP :
    eeprom_loader_pkg::OP_BYTE;

  // RULE7: byte plus ack slot; write slots release SDA for the ack
  // RULE2: fixed EEPROM address during autoload
  // RULE12: address, offset and data bytes of a write
  // RULE14: read direction and master ack after data
  wire [8:0] eng_tx =
    (state_reg == S_DEVW) ? {dev_addr, eeprom_loader_pkg::DIR_WR,
                             eeprom_loader_pkg::SDA_REL} :
    (state_reg == S_DEVR) ? {dev_addr, eeprom_loader_pkg::DIR_RD,
                             eeprom_loader_pkg::SDA_REL} :
    (state_reg == S_OFFS) ? {word_off, eeprom_loader_pkg::SDA_REL} :
    (state_reg == S_WDATA) ? {data_reg, eeprom_loader_pkg::SDA_REL} :
    {eeprom_loader_pkg::RD_FILL, eeprom_loader_pkg::ACK_LOW};

  wire [31:0] ctrl_rd = {26'h0, pres_reg, ldone_reg, auto_reg, nack_reg,
                         dir_reg, sw_busy};
  wire [31:0] misc_rd = {minirom_base, 7'h0, phy_prog_en, link_enh0,
                         max_lat, min_gnt};
  wire [31:0] rd_mux =
    (reg_addr == eeprom_loader_pkg::REG_CTRL) ? ctrl_rd :
    (reg_addr == eeprom_loader_pkg::REG_SLAVE) ? {25'h0, slave_reg} :
    (reg_addr == eeprom_loader_pkg::REG_OFFS) ? {24'h0, offs_reg} :
    (reg_addr == eeprom_loader_pkg::REG_DATA) ? {24'h0, data_reg} :
    (reg_addr == eeprom_loader_pkg::REG_SSYS) ? subsys_ids :
    (reg_addr == eeprom_loader_pkg::REG_GUIDH) ? guid_hi :
    (reg_addr == eeprom_loader_pkg::REG_GUIDL) ? guid_lo :
    (reg_addr == eeprom_loader_pkg::REG_MISC) ? misc_rd : 32'h0;

  assign load_busy = auto_reg;
  assign subsys_ids = ld_flat[31:0];
  assign guid_hi = ld_flat[63:32];
  assign guid_lo = ld_flat[95:64];

  ////////////////////////////////////////////////////////////////////////
  // Bit engine

  // RULE3: open-drain pins, enables only
  i2c_bit_engine u_engine (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .go(eng_go),
    .op(eng_op),
    .tx(eng_tx),
    .done(eng_done),
    .rx(eng_rx),
    .scl_level(scl_level),
    .scl_in(scl_in),
    .scl_out(scl_out),
    .scl_oe_n(scl_oe_n),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      // RULE15: leave reset state on PCI reset release
      // RULE20: pulled-up SCL means EEPROM present
      S_RESET: if (pci_ok) state_next = scl_level ? S_WAIT_CB : S_IDLE;
      // RULE21: wait for card functions to finish
      S_WAIT_CB: if (!cb_s2_reg) state_next = S_START;
      S_IDLE: begin
        if (!pci_ok) state_next = S_RESET;
        else if (sw_go) state_next = S_START;
      end
      S_START: if (eng_done) state_next = S_DEVW;
      S_DEVW: if (eng_done) state_next = eng_nack ? S_STOP : S_OFFS;
      S_OFFS: begin
        if (eng_done) begin
          if (eng_nack) state_next = S_STOP;
          else state_next = is_rd ? S_RSTART : S_WDATA;
        end
      end
      S_WDATA: if (eng_done) state_next = S_STOP;
      S_RSTART: if (eng_done) state_next = S_DEVR;
      S_DEVR: if (eng_done) state_next = eng_nack ? S_STOP : S_RDATA;
      S_RDATA: if (eng_done && last_rd) state_next = S_STOP;
      // RULE22: abort ends autoload at the stop
      S_STOP: begin
        if (eng_done) begin
          if (auto_reg && !abort_reg && rom_reg != eeprom_loader_pkg::ROM_END)
            state_next = S_START;
          else state_next = S_IDLE;
        end
      end
      default: state_next = S_RESET;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pci_s1_reg <= 1'b0;
      pci_s2_reg <= 1'b0;
      cb_s1_reg <= 1'b1;
      cb_s2_reg <= 1'b1;
    end else begin
      pci_s1_reg <= pci_rst_n;
      pci_s2_reg <= pci_s1_reg;
      cb_s1_reg <= cb_load_busy;
      cb_s2_reg <= cb_s1_reg;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= S_RESET;
      issued_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (eng_go) issued_reg <= 1'b1;
      else if (eng_done) issued_reg <= 1'b0;
    end
  end

  // RULE15: autoload flag and byte counter
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      auto_reg <= 1'b0;
      abort_reg <= 1'b0;
      rom_reg <= 5'h00;
      pres_reg <= 1'b0;
      ldone_reg <= 1'b0;
    end else if (clr_ld) begin
      auto_reg <= pci_ok && scl_level;
      abort_reg <= 1'b0;
      rom_reg <= 5'h00;
      pres_reg <= scl_level;
      ldone_reg <= 1'b0;
    end else begin
      if (auto_end && state_next == S_IDLE) auto_reg <= 1'b0;
      if (auto_end && state_next == S_IDLE) ldone_reg <= !abort_reg;
      // RULE22: remember the failed autoload
      if (ack_fail && auto_reg) abort_reg <= 1'b1;
      if (ld_we) rom_reg <= rom_reg + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Software registers

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dir_reg <= eeprom_loader_pkg::DIR_WR;
      slave_reg <= 7'h00;
      offs_reg <= 8'h00;
    end else if (cfg_wr) begin
      if (reg_addr == eeprom_loader_pkg::REG_CTRL)
        dir_reg <= reg_wdata[eeprom_loader_pkg::CTRL_DIR];
      if (reg_addr == eeprom_loader_pkg::REG_SLAVE)
        slave_reg <= reg_wdata[6:0];
      if (reg_addr == eeprom_loader_pkg::REG_OFFS)
        offs_reg <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) data_reg <= 8'h00;
    else if (eng_done && state_reg == S_RDATA && !auto_reg)
      data_reg <= rx_byte;
    else if (cfg_wr && reg_addr == eeprom_loader_pkg::REG_DATA)
      data_reg <= reg_wdata[7:0];
  end

  // RULE13: sticky no-ack, set wins over clear
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) nack_reg <= 1'b0;
    else if (ack_fail) nack_reg <= 1'b1;
    else if (ctrl_wr && reg_wdata[eeprom_loader_pkg::CTRL_NACK])
      nack_reg <= 1'b0;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) reg_rdata <= 32'h0;
    else reg_rdata <= reg_rd ? rd_mux : 32'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Loaded defaults

  // RULE17: subsystem IDs and GUID bytes, low byte first
  // RULE23: offset 0Fh, the only one outside the map, loads nothing
  for (genvar i = 0; i < eeprom_loader_pkg::LD_BYTES; i++) begin : g_ld
    logic [7:0] byte_reg;
    wire we = ld_we && ld_off == eeprom_loader_pkg::LD_OFF[i];
    always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) byte_reg <= eeprom_loader_pkg::DEF_BYTE;
      else if (clr_ld) byte_reg <= eeprom_loader_pkg::DEF_BYTE;
      else if (we) byte_reg <= rx_byte;
    end
    assign ld_flat[8*i +: 8] = byte_reg;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      max_lat <= 4'h0;
      min_gnt <= 4'h0;
    end else if (clr_ld) begin
      max_lat <= 4'h0;
      min_gnt <= 4'h0;
    // RULE16: split byte 00h
    end else if (ld_we && ld_off == eeprom_loader_pkg::ROM_LAT) begin
      max_lat <= rx_byte[7:4];
      min_gnt <= rx_byte[3:0];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      phy_prog_en <= 1'b0;
      link_enh0 <= 8'h00;
    end else if (clr_ld) begin
      phy_prog_en <= 1'b0;
      link_enh0 <= 8'h00;
    // RULE18: PHY enable and link bits 7, 2, 1
    end else if (ld_we && ld_off == eeprom_loader_pkg::ROM_LINK) begin
      phy_prog_en <= rx_byte[eeprom_loader_pkg::PHY_BIT];
      link_enh0 <= rx_byte & eeprom_loader_pkg::LINK_MASK;
    end
  end

  // RULE19: ROM start offset from bits 6:5
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) mini_reg <= 2'h0;
    else if (clr_ld) mini_reg <= 2'h0;
    else if (ld_we && ld_off == eeprom_loader_pkg::ROM_MINI)
      mini_reg <= rx_byte[eeprom_loader_pkg::MINI_LO +: 2];
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) minirom_base <= 8'h00;
    else minirom_base <= {1'b0, mini_reg, 5'h00};
  end
endmodule : eeprom_loader

/* verilog/eeprom_loader_pkg.sv */
// Constants shared by the EEPROM loader and its two-wire bit engine
package eeprom_loader_pkg;
  // Timing: quarter bit rounded up so SCL stays at or below 100 kHz
  localparam int CLK_NS = 40;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QTR_CYC = (SCL_PERIOD_NS / 4 + CLK_NS - 1) / CLK_NS;
  localparam int DIV_W = 7;
  localparam logic [DIV_W-1:0] QTR_LOAD = DIV_W'(QTR_CYC - 1);
  localparam logic [1:0] Q_RISE = 2'h0;
  localparam logic [1:0] Q_MID = 2'h1;
  localparam logic [1:0] Q_FALL = 2'h2;
  localparam logic [1:0] Q_END = 2'h3;
  localparam logic [3:0] LAST_BIT = 4'h8;
  typedef enum logic [1:0] {
    OP_START = 2'b00,
    OP_STOP = 2'b01,
    OP_BYTE = 2'b10
  } bus_op_t;
  // Addressing
  localparam logic [6:0] EEPROM_ADDR = 7'h50;
  localparam logic DIR_WR = 1'b0;
  localparam logic DIR_RD = 1'b1;
  localparam logic SDA_REL = 1'b1;
  localparam logic ACK_LOW = 1'b0;
  localparam logic [7:0] RD_FILL = 8'hFF;
  // Register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SLAVE = 8'h04;
  localparam logic [7:0] REG_OFFS = 8'h08;
  localparam logic [7:0] REG_DATA = 8'h0C;
  localparam logic [7:0] REG_SSYS = 8'h10;
  localparam logic [7:0] REG_GUIDH = 8'h14;
  localparam logic [7:0] REG_GUIDL = 8'h18;
  localparam logic [7:0] REG_MISC = 8'h1C;
  localparam int CTRL_GO = 0;
  localparam int CTRL_DIR = 1;
  localparam int CTRL_NACK = 2;
  // Load map
  localparam logic [3:0] ROM_LAT = 4'h0;
  localparam logic [3:0] ROM_LINK = 4'h5;
  localparam logic [3:0] ROM_MINI = 4'h6;
  localparam logic [4:0] ROM_END = 5'h10;
  localparam logic [1:0] DW_LAST = 2'h3;
  localparam logic [7:0] LINK_MASK = 8'h86;
  localparam int PHY_BIT = 6;
  localparam int MINI_LO = 5;
  localparam int LD_BYTES = 12;
  localparam logic [3:0] LD_OFF [LD_BYTES] = '{
    4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8,
    4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE};
  localparam logic [7:0] DEF_BYTE = 8'h00;
endpackage : eeprom_loader_pkg

/* verilog/i2c_bit_engine.sv */
// Two-wire bit engine: start, stop and nine-bit byte slots
`timescale 1ns/10ps
module i2c_bit_engine (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Command side
  input wire logic go,
  input wire eeprom_loader_pkg::bus_op_t op,
  input wire logic [8:0] tx,
  output logic done,
  output logic [8:0] rx,
  output logic scl_level,
  // Open-drain bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n
);
  eeprom_loader_pkg::bus_op_t op_reg;
  logic act_reg;
  logic [1:0] q_reg;
  logic [3:0] bit_reg;
  logic [8:0] sh_reg;
  logic [eeprom_loader_pkg::DIV_W-1:0] div_reg;
  logic scl_s1_reg, scl_s2_reg, sda_s1_reg, sda_s2_reg;

  wire start = go && !act_reg;
  wire tick = act_reg && (div_reg == '0);
  wire is_stop = op_reg == eeprom_loader_pkg::OP_STOP;
  wire is_start = op_reg == eeprom_loader_pkg::OP_START;
  wire is_byte = op_reg == eeprom_loader_pkg::OP_BYTE;
  wire q_last = tick && (is_stop ? q_reg == eeprom_loader_pkg::Q_FALL
                                 : q_reg == eeprom_loader_pkg::Q_END);
  wire fin = q_last && (!is_byte || bit_reg == eeprom_loader_pkg::LAST_BIT);

  // Only pulled low, never driven high
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_level = scl_s2_reg;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
    end else begin
      scl_s1_reg <= scl_in;
      scl_s2_reg <= scl_s1_reg;
      sda_s1_reg <= sda_in;
      sda_s2_reg <= sda_s1_reg;
    end
  end

  // RULE1: quarter-bit divider
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) div_reg <= '0;
    else if (start || tick) div_reg <= eeprom_loader_pkg::QTR_LOAD;
    else if (act_reg) div_reg <= div_reg - 1'b1;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      act_reg <= 1'b0;
      op_reg <= eeprom_loader_pkg::OP_START;
      q_reg <= 2'h0;
      bit_reg <= 4'h0;
      sh_reg <= 9'h1FF;
      done <= 1'b0;
    end else begin
      done <= fin;
      if (start) begin
        act_reg <= 1'b1;
        op_reg <= op;
        q_reg <= 2'h0;
        bit_reg <= 4'h0;
        sh_reg <= tx;
      end else if (fin) begin
        act_reg <= 1'b0;
      end else if (tick) begin
        q_reg <= q_reg + 1'b1;
        if (q_last) bit_reg <= bit_reg + 1'b1;
        if (q_reg == eeprom_loader_pkg::Q_END) sh_reg <= {sh_reg[7:0], 1'b1};
      end
    end
  end

  // RULE8: sample SDA mid high phase
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) rx <= 9'h000;
    else if (start) rx <= 9'h000;
    else if (tick && is_byte && q_reg == eeprom_loader_pkg::Q_MID)
      rx <= {rx[7:0], sda_s2_reg};
  end

  // RULE10: SCL released between a stop and the next start
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) scl_oe_n <= 1'b1;
    else if (tick && q_reg == eeprom_loader_pkg::Q_RISE) scl_oe_n <= 1'b1;
    else if (tick && !is_stop && q_reg == eeprom_loader_pkg::Q_FALL)
      scl_oe_n <= 1'b0;
  end

  // RULE6: SDA moves only while SCL low, except start and stop
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sda_oe_n <= 1'b1;
    end else if (start) begin
      if (op == eeprom_loader_pkg::OP_STOP) sda_oe_n <= 1'b0;
      else if (op == eeprom_loader_pkg::OP_START) sda_oe_n <= 1'b1;
      else sda_oe_n <= tx[8];
    end else if (tick && q_reg == eeprom_loader_pkg::Q_MID) begin
      // RULE4: start edge
      if (is_start) sda_oe_n <= 1'b0;
      // RULE5: stop edge
      if (is_stop) sda_oe_n <= 1'b1;
    end else if (tick && is_byte && !fin &&
                 q_reg == eeprom_loader_pkg::Q_END) begin
      sda_oe_n <= sh_reg[7];
    end
  end
endmodule : i2c_bit_engine

/* verification/eeprom_loader_assertions.sv */
// Bus timing and load sequencing checks for the EEPROM loader
`timescale 1ns/10ps
module eeprom_loader_assertions (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Load sequencing
  input wire logic pci_rst_n,
  input wire logic cb_load_busy,
  input wire logic load_busy,
  // Bus pins
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic sda_out,
  input wire logic sda_oe_n
);
  localparam int HALF = 2 * eeprom_loader_pkg::QTR_CYC;
  logic [7:0] hi_cnt;
  logic [7:0] lo_cnt;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Cycles SCL has been released or pulled, saturating
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      hi_cnt <= 8'h00;
      lo_cnt <= 8'h00;
    end else begin
      hi_cnt <= !scl_oe_n ? 8'h00 : hi_cnt + 8'(hi_cnt != 8'hFF);
      lo_cnt <= scl_oe_n ? 8'h00 : lo_cnt + 8'(lo_cnt != 8'hFF);
    end
  end
  chk_open_drain: assert property (!scl_out && !sda_out)
    else $error("bus pin driven high");
  chk_scl_high: assert property ($fell(scl_oe_n) |-> hi_cnt >= HALF)
    else $error("scl high phase too short");
  chk_scl_low: assert property ($rose(scl_oe_n) |-> lo_cnt >= HALF)
    else $error("scl low phase too short");
  chk_sda_stable: assert property (
    $changed(sda_oe_n) && scl_oe_n && $past(scl_oe_n) |-> hi_cnt >= 8'h20)
    else $error("sda moved right after scl rose");
  chk_start_cond: assert property (
    $fell(scl_oe_n) && hi_cnt == 8'hFF |-> $past(sda_oe_n, 32) == 1'b0)
    else $error("transfer began without start");
  chk_stop_cond: assert property (
    $rose(sda_oe_n) && scl_oe_n && $past(scl_oe_n) |-> scl_oe_n [*8])
    else $error("clock pulled after stop");
  chk_load_start: assert property (
    $rose(pci_rst_n) && scl_in |-> ##[1:8] load_busy)
    else $error("autoload not started");
  chk_load_skip: assert property (
    $rose(pci_rst_n) && !scl_in |-> !load_busy [*8])
    else $error("autoload without pullup");
  chk_load_wait: assert property (
    load_busy && cb_load_busy && $past(cb_load_busy, 4)
      |-> scl_oe_n && sda_oe_n)
    else $error("bus used before card load done");
endmodule : eeprom_loader_assertions

bind eeprom_loader eeprom_loader_assertions u_chk (
  .mclk(mclk), .sys_rst(sys_rst), .pci_rst_n(pci_rst_n),
  .cb_load_busy(cb_load_busy), .load_busy(load_busy), .scl_in(scl_in),
  .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n));

/* verification/eeprom_slave_model.sv */
// Two-wire EEPROM slave: word pointer, acks and read-back
`timescale 1ns/10ps
module eeprom_slave_model (
  // Wire levels
  input wire logic scl,
  input wire logic sda,
  // Refuse every ack
  input wire logic mute,
  // Open-drain pull on sda
  output logic pull
);
  logic [7:0] mem [256];
  logic [7:0] sh;
  logic [7:0] ptr;
  logic [1:0] ph;
  logic act = 1'b0;
  logic rd;
  logic tx;
  int n;
  initial pull = 1'b0;
  always @(negedge sda) if (scl) begin
    act = 1'b1;
    // The SCL fall that ends the start comes before bit one
    n = -1;
    ph = 2'h0;
    rd = 1'b0;
    tx = 1'b0;
  end
  always @(posedge sda) if (scl) act = 1'b0;
  // bits taken while the clock is high
  always @(posedge scl) if (act && n < 8) sh = {sh[6:0], sda};
  // sda moved only after the clock falls
  always @(negedge scl) if (act) begin
    n = n + 1;
    if (tx) begin
      if (n == 9) begin
        n = 0;
        ptr = ptr + 8'h01;
      end
      pull = (n < 8) && !mem[ptr][7 - n];
    end else if (n == 8) begin
      pull = !mute && (ph != 2'h0 || sh[7:1] == 7'h50);
      if (ph == 2'h0) rd = sh[0];
      if (ph == 2'h1) ptr = sh;
      if (ph == 2'h2) mem[ptr] = sh;
      if (ph == 2'h2) ptr = ptr + 8'h01;
    end else if (n == 9) begin
      n = 0;
      tx = rd;
      ph = (ph == 2'h2) ? ph : ph + 2'h1;
      pull = tx && !mem[ptr][7];
    end
  end
endmodule : eeprom_slave_model

/* verification/test_eeprom_loader.sv */
// Self-checking bench for the EEPROM loader and its two-wire master
`timescale 1ns/10ps
module test_eeprom_loader;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic pci_rst_n = 1'b0;
  logic cb_load_busy = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic scl_pu = 1'b1;
  logic mute = 1'b0;
  logic [31:0] reg_rdata, subsys_ids, guid_hi, guid_lo, d;
  logic scl_out, scl_oe_n, sda_out, sda_oe_n, pull, load_busy, phy;
  logic [3:0] max_lat, min_gnt;
  logic [7:0] link_enh0, minirom_base, b5, b6;
  logic [7:0] row_a [5];
  logic [31:0] row_e [5];
  int errors = 0;
  int comparisons = 0;
  wire scl_w;
  wire sda_w;
  assign scl_w = scl_oe_n ? scl_pu : 1'b0;
  assign sda_w = sda_oe_n && !pull;
  always #20 mclk = ~mclk;
  eeprom_loader DUT (.mclk(mclk), .sys_rst(sys_rst), .pci_rst_n(pci_rst_n),
    .cb_load_busy(cb_load_busy), .load_busy(load_busy),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_w),
    .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .max_lat(max_lat),
    .min_gnt(min_gnt), .subsys_ids(subsys_ids), .phy_prog_en(phy),
    .link_enh0(link_enh0), .minirom_base(minirom_base),
    .guid_hi(guid_hi), .guid_lo(guid_lo));
  eeprom_slave_model slave (.scl(scl_w), .sda(sda_w), .mute(mute),
    .pull(pull));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rom(input int i);
    rom = 8'h80 | (8'(i) * 8'h0D);
  endfunction : rom
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    d = reg_rdata;
  endtask : rd
  task automatic sw_go(input logic dir);
    wr(eeprom_loader_pkg::REG_CTRL, {30'h0, dir, 1'b1});
    d = 32'h1;
    for (int i = 0; i < 12000 && d[0] !== 1'b0; i++) begin
      rd(eeprom_loader_pkg::REG_CTRL);
    end
    chk(32'(d[0]), 32'h0);
  endtask : sw_go
  task automatic wait_load();
    for (int i = 0; i < 90000 && load_busy !== 1'b0; i++) begin
      @(posedge mclk);
    end
    chk(32'(load_busy), 32'h0);
  endtask : wait_load
  task automatic end_sim();
    if (errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(98000 * 40);
    errors++;
    end_sim();
  end
  initial begin
    for (int i = 0; i < 256; i++) begin
      slave.mem[i] = rom(i);
    end
    b5 = rom(5);
    b6 = rom(6);
    row_a = '{eeprom_loader_pkg::REG_SSYS, eeprom_loader_pkg::REG_GUIDH,
      eeprom_loader_pkg::REG_GUIDL, eeprom_loader_pkg::REG_MISC, 8'h20};
    row_e[0] = {rom(4), rom(3), rom(2), rom(1)};
    row_e[1] = {rom(10), rom(9), rom(8), rom(7)};
    row_e[2] = {rom(14), rom(13), rom(12), rom(11)};
    row_e[3] = {1'b0, b6[6:5], 12'h000, b5[6], b5 & 8'h86, rom(0)};
    row_e[4] = 32'h0;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    chk(32'({load_busy, scl_oe_n, sda_oe_n, max_lat}), 32'h30);
    pci_rst_n <= 1'b1;
    repeat (30) @(posedge mclk);
    chk(32'({load_busy, scl_oe_n, sda_oe_n}), 32'h7);
    cb_load_busy <= 1'b0;
    wait_load();
    for (int r = 0; r < 5; r++) begin
      rd(row_a[r]);
      chk(d, row_e[r]);
    end
    chk(subsys_ids, row_e[0]);
    chk(guid_hi, row_e[1]);
    chk(guid_lo, row_e[2]);
    chk(32'({max_lat, min_gnt}), 32'(rom(0)));
    chk(32'({phy, link_enh0}), 32'({b5[6], b5 & 8'h86}));
    chk(32'(minirom_base), 32'({1'b0, b6[6:5], 5'h00}));
    rd(eeprom_loader_pkg::REG_CTRL);
    chk(32'(d[5:0]), 32'h30);
    wr(eeprom_loader_pkg::REG_SLAVE, 32'h50);
    wr(eeprom_loader_pkg::REG_OFFS, 32'h30);
    wr(eeprom_loader_pkg::REG_DATA, 32'h5A);
    sw_go(1'b0);
    chk(32'(slave.mem[8'h30]), 32'h5A);
    chk(32'(slave.mem[8'h31]), 32'(rom(32'h31)));
    wr(eeprom_loader_pkg::REG_OFFS, 32'h40);
    sw_go(1'b1);
    rd(eeprom_loader_pkg::REG_DATA);
    chk(d, 32'(rom(32'h40)));
    mute <= 1'b1;
    sw_go(1'b0);
    rd(eeprom_loader_pkg::REG_CTRL);
    chk(32'(d[2]), 32'h1);
    wr(eeprom_loader_pkg::REG_CTRL, 32'h4);
    rd(eeprom_loader_pkg::REG_CTRL);
    chk(32'(d[2]), 32'h0);
    // Autoload into a silent EEPROM gives up and keeps defaults
    pci_rst_n <= 1'b0;
    repeat (10) @(posedge mclk);
    chk(subsys_ids | guid_lo, 32'h0);
    pci_rst_n <= 1'b1;
    repeat (10) @(posedge mclk);
    wait_load();
    rd(eeprom_loader_pkg::REG_CTRL);
    chk(32'(d[5:2]), 32'h9);
    chk(subsys_ids | guid_hi, 32'h0);
    // Without the SCL pullup no load is tried
    mute <= 1'b0;
    wr(eeprom_loader_pkg::REG_CTRL, 32'h4);
    pci_rst_n <= 1'b0;
    scl_pu <= 1'b0;
    repeat (10) @(posedge mclk);
    pci_rst_n <= 1'b1;
    repeat (20) @(posedge mclk);
    rd(eeprom_loader_pkg::REG_CTRL);
    chk(32'({load_busy, d[5:3]}), 32'h0);
    end_sim();
  end
endmodule : test_eeprom_loader
